// File: rtl/nci_host.sv
// host controller issuing commands, addresses and id reads to a nand flash
// assumes a single clock; io_i and rb_n_i are synchronous to clk_i
`default_nettype none

module nci_host (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	// software register port
	input  wire logic [2:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	// flash pins
	output nci_pkg::nci_pins_t     pins_o,
	input  wire logic [7:0]        io_i,
	input  wire logic              rb_n_i
);
	import nci_pkg::*;
	`include "nci_defines.svh"

	localparam int WP_C  = nci_cyc(`NCI_T_WP_NS, `NCI_CLK_MHZ);
	localparam int WH_C  = nci_cyc(`NCI_T_WH_NS, `NCI_CLK_MHZ);
	localparam int REA_C = nci_cyc(`NCI_T_REA_NS, `NCI_CLK_MHZ);
	localparam int REH_C = nci_cyc(`NCI_T_REH_NS, `NCI_CLK_MHZ);
	localparam int WHR_C = nci_cyc(`NCI_T_WHR_NS, `NCI_CLK_MHZ);

	// ==========================================
	// state
	nci_state_t  st_r,    st_nxt;
	nci_op_t     op_r,    op_nxt;
	logic [7:0]  cmd_r,   cmd_nxt;
	logic [2:0]  acnt_r,  acnt_nxt;
	logic [2:0]  aidx_r,  aidx_nxt;
	logic [3:0]  rcnt_r,  rcnt_nxt;
	logic [2:0]  ridx_r,  ridx_nxt;
	logic [2:0]  tcnt_r,  tcnt_nxt;
	logic        half_r,  half_nxt;
	logic        dum_r,   dum_nxt;
	logic        idm_r,   idm_nxt;
	logic        ref_r,   ref_nxt;
	logic [7:0]  stb_r,   stb_nxt;
	logic [31:0] data_r,  data_nxt;
	logic [7:0]  id_r     [`NCI_ID_BYTES];
	logic [7:0]  id_nxt   [`NCI_ID_BYTES];
	nci_pins_t   pins_r,  pins_nxt;
	logic        wp_r,    wp_nxt;
	logic [11:0] col_r,   col_nxt;
	logic [18:0] row_r,   row_nxt;
	logic [31:0] rdat_r,  rdat_nxt;
	logic        launch;
	logic        wr_st;
	logic [7:0]  abyte;
	logic [7:0]  xcmd;
	logic [2:0]  acyc;

	assign launch = wr_i && (addr_i == `NCI_REG_CMD) && (st_r == NCI_ST_IDLE);
	assign acyc   = (wdata_i[`NCI_CMD_ACNT_LSB +: 3] > `NCI_MAX_ACYC) ?
	                `NCI_MAX_ACYC : wdata_i[`NCI_CMD_ACNT_LSB +: 3];
	assign pins_o = pins_r;
	assign rdata_o = rdat_r;

	nci_addr_fmt u_fmt (
		.col_i     (col_r),
		.row_i     (row_r),
		.idx_i     (aidx_nxt),
		.byte_o    (abyte),
		.xst_cmd_o (xcmd)
	);

	// ==========================================
	// software registers and read data, one cycle after rd_i
	always_comb begin
		wp_nxt   = wp_r;
		col_nxt  = col_r;
		row_nxt  = row_r;
		rdat_nxt = 32'h0000_0000;
		if (wr_i && addr_i == `NCI_REG_CTRL) wp_nxt = wdata_i[`NCI_CTRL_WP_BIT];
		if (wr_i && addr_i == `NCI_REG_COL && st_r == NCI_ST_IDLE) col_nxt = wdata_i[11:0];
		if (wr_i && addr_i == `NCI_REG_ROW && st_r == NCI_ST_IDLE) row_nxt = wdata_i[18:0];
		if (rd_i) begin
			unique case (addr_i)
				`NCI_REG_CTRL: rdat_nxt = {31'h0, wp_r};
				`NCI_REG_COL:  rdat_nxt = {20'h0, col_r};
				`NCI_REG_ROW:  rdat_nxt = {13'h0, row_r};
				`NCI_REG_CMD:  rdat_nxt = 32'h0000_0000;
				`NCI_REG_STAT: rdat_nxt = {16'h0, stb_r, 4'h0, ref_r, idm_r,
				                           rb_n_i, st_r != NCI_ST_IDLE};
				`NCI_REG_ID0:  rdat_nxt = {id_r[3], id_r[2], id_r[1], id_r[0]};
				`NCI_REG_ID1:  rdat_nxt = {12'h0, 4'(4'h1 << id_r[4][3:2]),
				                           1'b0, id_r[4][6:4], 2'h0, id_r[4][3:2],
				                           id_r[4]};
				`NCI_REG_DATA: rdat_nxt = data_r;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_r   <= `NCI_CTRL_RST;
			col_r  <= 12'h000;
			row_r  <= 19'h00000;
			rdat_r <= 32'h0000_0000;
		end else begin
			wp_r   <= wp_nxt;
			col_r  <= col_nxt;
			row_r  <= row_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// ==========================================
	// bus cycle sequencer
	always_comb begin
		st_nxt   = st_r;
		op_nxt   = op_r;
		cmd_nxt  = cmd_r;
		acnt_nxt = acnt_r;
		aidx_nxt = aidx_r;
		rcnt_nxt = rcnt_r;
		ridx_nxt = ridx_r;
		tcnt_nxt = tcnt_r;
		half_nxt = half_r;
		dum_nxt  = dum_r;
		idm_nxt  = idm_r;
		stb_nxt  = stb_r;
		data_nxt = data_r;
		id_nxt   = id_r;
		ref_nxt  = ref_r;
		if (wr_i && addr_i == `NCI_REG_CMD) ref_nxt = !launch;
		unique case (st_r)
			NCI_ST_IDLE: begin
				if (launch) begin
					op_nxt   = nci_op_t'(wdata_i[`NCI_CMD_OP_LSB +: 2]);
					tcnt_nxt = 3'(WP_C - 1);
					half_nxt = 1'b0;
					aidx_nxt = 3'h0;
					ridx_nxt = 3'h0;
					acnt_nxt = 3'h0;
					rcnt_nxt = 4'h1;
					dum_nxt  = idm_r;
					unique case (nci_op_t'(wdata_i[`NCI_CMD_OP_LSB +: 2]))
						NCI_OP_ID: begin
							cmd_nxt  = `NCI_OPC_ID;
							acnt_nxt = 3'h1;
							rcnt_nxt = 4'(`NCI_ID_BYTES);
							dum_nxt  = 1'b0;
						end
						NCI_OP_STAT: cmd_nxt = `NCI_OPC_STATUS;
						NCI_OP_XST:  cmd_nxt = xcmd;
						NCI_OP_RAW: begin
							cmd_nxt  = wdata_i[`NCI_CMD_RAW_LSB +: 8];
							acnt_nxt = acyc;
							aidx_nxt = (acyc == 3'h3) ? 3'h2 : 3'h0;
							rcnt_nxt = wdata_i[`NCI_CMD_RCNT_LSB +: 4];
							dum_nxt  = 1'b0;
						end
					endcase
					if (nci_op_t'(wdata_i[`NCI_CMD_OP_LSB +: 2]) == NCI_OP_RAW)
						st_nxt = NCI_ST_WAIT;
					else
						st_nxt = dum_nxt ? NCI_ST_DUMMY : NCI_ST_CMD;
				end
			end
			NCI_ST_WAIT: begin
				if (rb_n_i) st_nxt = NCI_ST_CMD;
			end
			NCI_ST_DUMMY, NCI_ST_CMD, NCI_ST_ADDR: begin
				if (tcnt_r != 3'h0) begin
					tcnt_nxt = tcnt_r - 3'h1;
				end else if (!half_r) begin
					half_nxt = 1'b1;
					tcnt_nxt = 3'(WH_C - 1);
				end else begin
					half_nxt = 1'b0;
					tcnt_nxt = 3'(WP_C - 1);
					if (st_r == NCI_ST_DUMMY) begin
						idm_nxt = 1'b0;
						st_nxt  = NCI_ST_CMD;
					end else begin
						if (st_r == NCI_ST_CMD) begin
							idm_nxt = (op_r == NCI_OP_ID);
						end else begin
							acnt_nxt = acnt_r - 3'h1;
							aidx_nxt = aidx_r + 3'h1;
						end
						if (acnt_nxt != 3'h0) begin
							st_nxt = NCI_ST_ADDR;
						end else if (rcnt_r != 4'h0) begin
							st_nxt   = NCI_ST_GAP;
							tcnt_nxt = 3'(WHR_C - 1);
						end else begin
							st_nxt = NCI_ST_IDLE;
						end
					end
				end
			end
			NCI_ST_GAP: begin
				if (tcnt_r != 3'h0) begin
					tcnt_nxt = tcnt_r - 3'h1;
				end else begin
					st_nxt   = NCI_ST_READ;
					half_nxt = 1'b0;
					tcnt_nxt = 3'(REA_C - 1);
				end
			end
			NCI_ST_READ: begin
				if (tcnt_r != 3'h0) begin
					tcnt_nxt = tcnt_r - 3'h1;
				end else if (!half_r) begin
					half_nxt = 1'b1;
					tcnt_nxt = 3'(REH_C - 1);
					if (op_r == NCI_OP_ID)
						id_nxt[ridx_r] = io_i;
					else if (op_r == NCI_OP_RAW)
						data_nxt = {data_r[23:0], io_i};
					else
						stb_nxt = io_i;
				end else begin
					half_nxt = 1'b0;
					tcnt_nxt = 3'(REA_C - 1);
					rcnt_nxt = rcnt_r - 4'h1;
					ridx_nxt = ridx_r + 3'h1;
					st_nxt   = (rcnt_nxt != 4'h0) ? NCI_ST_READ : NCI_ST_IDLE;
				end
			end
			default: st_nxt = NCI_ST_IDLE;
		endcase
		// pin values follow the next state
		wr_st            = st_nxt inside {NCI_ST_DUMMY, NCI_ST_CMD, NCI_ST_ADDR};
		pins_nxt.cle     = st_nxt inside {NCI_ST_DUMMY, NCI_ST_CMD};
		pins_nxt.ale     = st_nxt == NCI_ST_ADDR;
		pins_nxt.we_n    = !(wr_st && !half_nxt);
		pins_nxt.read_strobe_n = !(st_nxt == NCI_ST_READ && !half_nxt);
		pins_nxt.ce_n    = st_nxt == NCI_ST_IDLE;
		pins_nxt.wp_n    = wp_r;
		pins_nxt.io_oe_n = !wr_st;
		if (st_nxt == NCI_ST_DUMMY)
			pins_nxt.io = `NCI_OPC_DUMMY;
		else if (st_nxt == NCI_ST_CMD)
			pins_nxt.io = cmd_nxt;
		else if (st_nxt == NCI_ST_ADDR)
			pins_nxt.io = (op_nxt == NCI_OP_ID) ? `NCI_OPC_ID_ADDR : abyte;
		else
			pins_nxt.io = 8'h00;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r   <= NCI_ST_IDLE;
			op_r   <= NCI_OP_ID;
			cmd_r  <= 8'h00;
			acnt_r <= 3'h0;
			aidx_r <= 3'h0;
			rcnt_r <= 4'h0;
			ridx_r <= 3'h0;
			tcnt_r <= 3'h0;
			half_r <= 1'b0;
			dum_r  <= 1'b0;
			idm_r  <= 1'b0;
			ref_r  <= 1'b0;
			stb_r  <= 8'h00;
			data_r <= 32'h0000_0000;
			for (int i = 0; i < `NCI_ID_BYTES; i++) id_r[i] <= 8'h00;
			pins_r <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1,
			           wp_n: `NCI_CTRL_RST, io_oe_n: 1'b1, io: 8'h00};
		end else begin
			st_r   <= st_nxt;
			op_r   <= op_nxt;
			cmd_r  <= cmd_nxt;
			acnt_r <= acnt_nxt;
			aidx_r <= aidx_nxt;
			rcnt_r <= rcnt_nxt;
			ridx_r <= ridx_nxt;
			tcnt_r <= tcnt_nxt;
			half_r <= half_nxt;
			dum_r  <= dum_nxt;
			idm_r  <= idm_nxt;
			ref_r  <= ref_nxt;
			stb_r  <= stb_nxt;
			data_r <= data_nxt;
			id_r   <= id_nxt;
			pins_r <= pins_nxt;
		end
	end

	// ==========================================
	// checks on the pin sequencing
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_wr_low;   !pins_r.we_n && pins_r.cle;          endsequence
	sequence s_stall;    st_r == NCI_ST_WAIT && !rb_n_i;       endsequence
	sequence s_id_go;    launch && wdata_i[1:0] == 2'h0;       endsequence
	sequence s_st_go;    launch && wdata_i[1:0] == 2'h1 && idm_r; endsequence

	property p_latch_excl; !(pins_r.cle && pins_r.ale);            endproperty
	property p_drive_wr;   !pins_r.we_n |-> !pins_r.io_oe_n && pins_r.read_strobe_n; endproperty
	property p_float_rd;   !pins_r.read_strobe_n |-> pins_r.io_oe_n && pins_r.we_n; endproperty
	property p_sel;        (!pins_r.we_n || !pins_r.read_strobe_n) |-> !pins_r.ce_n; endproperty
	property p_cmd_hold;   $fell(pins_r.we_n) ##0 s_wr_low |=> $stable(pins_r.io); endproperty
	property p_col_hi;     st_r == NCI_ST_ADDR && op_r == NCI_OP_RAW && aidx_r == 3'h1
	                       |-> pins_r.io[7:4] == 4'h0; endproperty
	property p_row3_hi;    st_r == NCI_ST_ADDR && aidx_r == 3'h4 |-> pins_r.io[7:3] == 5'h00;
	endproperty
	property p_wait;       s_stall |=> st_r == NCI_ST_WAIT && pins_r.we_n; endproperty
	property p_id;         s_id_go |=> pins_r.cle && pins_r.io == 8'h90
	                       ##[1:8] pins_r.ale && pins_r.io == 8'h00; endproperty
	property p_dummy;      s_st_go |=> pins_r.cle && pins_r.io == 8'h00
	                       ##[1:8] pins_r.cle && pins_r.io == 8'h70; endproperty
	property p_xst;        st_r == NCI_ST_CMD && op_r == NCI_OP_XST
	                       |-> pins_r.io == (row_r[18] ? 8'hF3 : 8'hF2); endproperty

	a_latch_excl: assert property (p_latch_excl) else $error("cle and ale both high");
	a_drive_wr:   assert property (p_drive_wr) else $error("bus not driven on write");
	a_float_rd:   assert property (p_float_rd) else $error("bus driven during read");
	a_sel:        assert property (p_sel) else $error("strobe without chip select");
	a_cmd_hold:   assert property (p_cmd_hold) else $error("command byte moved");
	a_col_hi:     assert property (p_col_hi) else $error("column high lines not low");
	a_row3_hi:    assert property (p_row3_hi) else $error("fifth cycle lines not low");
	a_wait:       assert property (p_wait) else $error("array op issued while busy");
	a_id:         assert property (p_id) else $error("bad id entry sequence");
	a_dummy:      assert property (p_dummy) else $error("no dummy before status");
	a_xst:        assert property (p_xst) else $error("wrong die status command");

endmodule : nci_host

`default_nettype wire

// File: shared/nci_defines.svh
// constants for the nand command/address/id host controller
// assumes a 40 MHz clk_i and one nand package on the pins
// Behaviour
// - column is twelve bits over two cycles, upper lines low in second
// - third cycle page, plane, block bit 0; fourth cycle block bits 1 to 8
// - fifth cycle carries block bits 9 to 11, other lines low
// - extended status uses F2h for low rows, F3h for rows from 40000h
// - id mode is command 90h then one address cycle 00h
// - after an id read send dummy 00h before status 70h
`ifndef NCI_DEFINES_SVH
`define NCI_DEFINES_SVH

// ==========================================
// register word offsets
`define NCI_REG_CTRL      3'h0
`define NCI_REG_COL       3'h1
`define NCI_REG_ROW       3'h2
`define NCI_REG_CMD       3'h3
`define NCI_REG_STAT      3'h4
`define NCI_REG_ID0       3'h5
`define NCI_REG_ID1       3'h6
`define NCI_REG_DATA      3'h7

// ==========================================
// field positions and reset values
`define NCI_CTRL_WP_BIT   0
`define NCI_CTRL_RST      1'h0
`define NCI_CMD_OP_LSB    0
`define NCI_CMD_RAW_LSB   8
`define NCI_CMD_ACNT_LSB  16
`define NCI_CMD_RCNT_LSB  20
`define NCI_STAT_BUSY     0
`define NCI_STAT_RB       1
`define NCI_STAT_IDMODE   2
`define NCI_STAT_REFUSED  3
`define NCI_STAT_BYTE_LSB 8
`define NCI_ID1_PLN_LSB   8
`define NCI_ID1_SIZE_LSB  12
`define NCI_ID1_NPLN_LSB  16
`define NCI_ROW_DIE_BIT   18
`define NCI_ID_BYTES      5
`define NCI_MAX_ACYC      3'h5

// ==========================================
// command codes
`define NCI_OPC_ID        8'h90
`define NCI_OPC_ID_ADDR   8'h00
`define NCI_OPC_DUMMY     8'h00
`define NCI_OPC_STATUS    8'h70
`define NCI_OPC_XST_D0    8'hF2
`define NCI_OPC_XST_D1    8'hF3

// ==========================================
// timing in ns and clock rate
`define NCI_CLK_MHZ       40
`define NCI_T_WP_NS       12
`define NCI_T_WH_NS       10
`define NCI_T_REA_NS      20
`define NCI_T_REH_NS      10
`define NCI_T_WHR_NS      60

`endif

// File: shared/nci_pkg.sv
// types of the nand command/address/id host controller
// assumes nci_defines.svh for every number
`default_nettype none

package nci_pkg;

	// ==========================================
	// sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		NCI_ST_IDLE  = 3'h0,
		NCI_ST_WAIT  = 3'h1,
		NCI_ST_DUMMY = 3'h3,
		NCI_ST_CMD   = 3'h2,
		NCI_ST_ADDR  = 3'h6,
		NCI_ST_GAP   = 3'h7,
		NCI_ST_READ  = 3'h5
	} nci_state_t;

	// operations software may launch
	typedef enum logic [1:0] {
		NCI_OP_ID   = 2'h0,
		NCI_OP_STAT = 2'h1,
		NCI_OP_XST  = 2'h2,
		NCI_OP_RAW  = 2'h3
	} nci_op_t;

	// pins driven toward the flash
	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ce_n;
		logic       we_n;
		logic       read_strobe_n;
		logic       wp_n;
		logic       io_oe_n;
		logic [7:0] io;
	} nci_pins_t;

	// ns to whole clock cycles, rounded up, at least one
	function automatic int nci_cyc(input int ns, input int mhz);
		int c;
		c = (ns * mhz + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : nci_cyc

endpackage : nci_pkg

`default_nettype wire

// File: rtl/nci_addr_fmt.sv
// address cycle byte former and die decode
// assumes row layout block[18:7], plane[6], page[5:0]
`default_nettype none

module nci_addr_fmt (
	// address source
	input  wire logic [11:0] col_i,
	input  wire logic [18:0] row_i,
	input  wire logic [2:0]  idx_i,
	// results
	output logic      [7:0]  byte_o,
	output logic      [7:0]  xst_cmd_o
);
	import nci_pkg::*;
	`include "nci_defines.svh"

	// ==========================================
	// one byte per address cycle
	always_comb begin
		unique case (idx_i)
			3'h0:    byte_o = col_i[7:0];
			3'h1:    byte_o = {4'h0, col_i[11:8]};
			3'h2:    byte_o = row_i[7:0];
			3'h3:    byte_o = row_i[15:8];
			3'h4:    byte_o = {5'h00, row_i[18:16]};
			default: byte_o = 8'h00;
		endcase
	end

	// die chosen by the top row bit
	assign xst_cmd_o = row_i[`NCI_ROW_DIE_BIT] ? `NCI_OPC_XST_D1 : `NCI_OPC_XST_D0;

endmodule : nci_addr_fmt

`default_nettype wire

// File: verif/nci_flash_model.sv
// behavioural nand flash answering the host controller on its pins
// assumes pins are sampled on clk_i; the bench resolves io and ready/busy
`default_nettype none

module nci_flash_model
	import nci_pkg::*;
#(
	parameter logic [31:0] ID_LO = 32'h3C5A_6B7E, // arbitrary id bytes 4..1
	parameter logic [7:0]  ST_OK = 8'hE0,
	parameter logic [7:0]  ST_D0 = 8'hC1,
	parameter logic [7:0]  ST_D1 = 8'hC2
) (
	// clock, reset and stimulus
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	input  wire nci_pkg::nci_pins_t pins_i,
	input  wire logic               busy_i,
	input  wire logic [7:0]         id5_i,
	// flash outputs and observation
	output logic      [7:0]         io_o,
	output logic                    rb_low_o,
	output logic      [7:0]         cmd_o,
	output logic      [7:0]         prev_o,
	output logic      [11:0]        col_o,
	output logic      [18:0]        row_o,
	output logic      [8:0]         pad_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// state
	logic [7:0] ab [5];
	logic [2:0] acnt;
	logic [3:0] rcnt;
	logic       we_q;
	logic       rstb_q;
	logic       idm;
	logic       drv;
	logic [7:0] last;
	logic [7:0] dout;

	// ==========================================
	// bus and address views
	assign drv = !pins_i.ce_n && !pins_i.read_strobe_n && pins_i.io_oe_n;
	assign io_o = drv ? dout : ~last;
	assign rb_low_o = busy_i;
	assign col_o = {ab[1][3:0], ab[0]};
	assign row_o = {ab[4][2:0], ab[3], ab[2]};
	assign pad_o = {ab[1][7:4], ab[4][7:3]};

	// output byte by current command
	always_comb begin
		case (cmd_o)
			8'h70: dout = ST_OK;
			8'hF2: dout = ST_D0;
			8'hF3: dout = ST_D1;
			default: dout = idm ? ((rcnt > 4'h3) ? id5_i : ID_LO[{rcnt, 3'b0} +: 8])
				: ab[0] + 8'(rcnt);
		endcase
	end

	// strobe edges found from previous pin levels
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			we_q <= 1'b1;
			rstb_q <= 1'b1;
			idm <= 1'b0;
			acnt <= 3'h0;
			rcnt <= 4'h0;
			cmd_o <= 8'hFF;
			prev_o <= 8'hFF;
			last <= 8'h00;
			ab <= '{default: 8'h00};
		end else begin
			we_q <= pins_i.we_n;
			rstb_q <= pins_i.read_strobe_n;
			if (drv)
				last <= dout;
			if (!pins_i.ce_n && pins_i.we_n && !we_q) begin
				if (pins_i.cle) begin
					prev_o <= cmd_o;
					cmd_o <= pins_i.io;
					acnt <= 3'h0;
					rcnt <= 4'h0;
					idm <= 1'b0;
				end else if (pins_i.ale) begin
					ab[acnt] <= pins_i.io;
					acnt <= acnt + 3'h1;
					idm <= (cmd_o == 8'h90) && (acnt == 3'h0) && (pins_i.io == 8'h00);
				end
			end
			if (drv && rstb_q)
				rcnt <= rcnt + 4'h1;
		end
	end

endmodule : nci_flash_model

`default_nettype wire

// File: verif/nci_host_bench.sv
// self-checking bench for the nand host controller
// assumes nci_flash_model on the pins and a pull-up on ready/busy
`default_nettype none
`include "nci_defines.svh"

module nci_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import nci_pkg::*;

	// ==========================================
	// signals
	localparam logic [31:0] ID_LO = 32'h3C5A_6B7E; // arbitrary id bytes 4..1
	logic        clk_i    = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [2:0]  addr_i   = 3'h0;
	logic [31:0] wdata_i  = 32'h0;
	logic        wr_i     = 1'b0;
	logic        rd_i     = 1'b0;
	logic        want     = 1'b0;
	logic        pend     = 1'b0;
	logic        busy_m   = 1'b0;
	logic        rb_low;
	logic [7:0]  id5      = 8'h00;
	logic [7:0]  io_fl;
	logic [7:0]  cmd_m;
	logic [7:0]  prev_m;
	logic [31:0] rdata_o;
	nci_pins_t   pins;
	logic [11:0] col_m;
	logic [18:0] row_m;
	logic [8:0]  pad_m;
	logic [31:0] q[$];
	int          fails    = 0;
	int          n_checks = 0;

	// ==========================================
	// design and flash
	nci_host i_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_o(pins),
		.io_i(pins.io_oe_n ? io_fl : pins.io), .rb_n_i(!rb_low)
	);
	nci_flash_model #(.ID_LO(ID_LO)) i_flash (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .pins_i(pins), .busy_i(busy_m), .id5_i(id5),
		.io_o(io_fl), .rb_low_o(rb_low), .cmd_o(cmd_m), .prev_o(prev_m), .col_o(col_m),
		.row_o(row_m), .pad_o(pad_m)
	);

	// clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		want <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic c);
		addr_i <= a;
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		want <= c;
		if (c)
			q.push_back(e);
		@(posedge clk_i);
	endtask : rd

	task automatic idle();
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		want <= 1'b0;
		@(posedge clk_i);
	endtask : idle

	// poll busy without noting a result
	task automatic wait_idle();
		int n;
		for (n = 0; n < 100; n++) begin
			rd(`NCI_REG_STAT, 32'h0, 1'b0);
			rd_i <= 1'b0;
			@(negedge clk_i);
			if (rdata_o[0] === 1'b0)
				break;
			@(posedge clk_i);
		end
		if (n == 100)
			chk(32'h1, 32'h0);
		@(posedge clk_i);
	endtask : wait_idle

	function automatic logic [31:0] stat(input logic [7:0] sb, input logic rf, im, rb, bz);
		return {16'h0, sb, 4'h0, rf, im, rb, bz};
	endfunction : stat

	// read data compared one cycle after each noted read
	always @(negedge clk_i) begin
		if (pend)
			chk(rdata_o, q.pop_front());
		pend = rd_i & want;
	end

	// watchdog
	initial begin
		#100us;
		fails++;
		report_and_stop();
	end

	// ==========================================
	// main sequence
	initial begin
		int          k;
		logic [1:0]  pl;
		logic [2:0]  sz;
		logic [11:0] col;
		logic [18:0] row;
		logic [31:0] e;
		logic [7:0]  sb;
		void'($urandom(32'h77DA));
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({17'h0, pins}, 32'h0000_1D00);
		@(posedge clk_i);
		rd(`NCI_REG_CTRL, 32'h0, 1'b1);
		rd(`NCI_REG_STAT, stat(8'h00, 0, 0, 1, 0), 1'b1);
		wr(`NCI_REG_CTRL, 32'h1);
		idle();
		@(negedge clk_i);
		chk({31'h0, pins.wp_n}, 32'h1);
		@(posedge clk_i);
		// id reads with random fifth byte fields
		sb = 8'h00;
		for (k = 0; k < 3; k++) begin
			pl = 2'($urandom_range(3, 0));
			sz = 3'($urandom_range(7, 0));
			id5 <= {1'b0, sz, pl, 2'b00};
			wr(`NCI_REG_CMD, 32'h0);
			idle();
			wait_idle();
			chk({24'h0, cmd_m}, 32'h90);
			e = {12'h0, 4'h1 << pl, 1'b0, sz, 2'b00, pl, 1'b0, sz, pl, 2'b00};
			rd(`NCI_REG_ID0, ID_LO, 1'b1);
			rd(`NCI_REG_ID1, e, 1'b1);
			rd(`NCI_REG_STAT, stat(sb, 0, 1, 1, 0), 1'b1);
			idle();
		end
		// status after id needs the dummy command first
		wr(`NCI_REG_CMD, 32'h1);
		idle();
		wait_idle();
		chk({prev_m, cmd_m}, 32'h0070);
		sb = 8'hE0;
		rd(`NCI_REG_STAT, stat(sb, 0, 0, 1, 0), 1'b1);
		// extended status on each die
		for (k = 0; k < 2; k++) begin
			wr(`NCI_REG_ROW, {13'h0, k[0], 18'($urandom)});
			wr(`NCI_REG_CMD, 32'h2);
			idle();
			wait_idle();
			chk({24'h0, cmd_m}, 32'hF2 + k);
			sb = k[0] ? 8'hC2 : 8'hC1;
			rd(`NCI_REG_STAT, stat(sb, 0, 0, 1, 0), 1'b1);
			idle();
		end
		// raw five-cycle read held off by busy, second launch refused
		col = 12'($urandom);
		row = 19'($urandom);
		busy_m <= 1'b1;
		wr(`NCI_REG_COL, {20'h0, col});
		wr(`NCI_REG_ROW, {13'h0, row});
		wr(`NCI_REG_CMD, 32'h0025_0003);
		idle();
		repeat (8) @(posedge clk_i);
		wr(`NCI_REG_CMD, 32'h0025_0003);
		rd(`NCI_REG_STAT, stat(sb, 1, 0, 0, 1), 1'b1);
		chk({24'h0, cmd_m}, 32'hF3);
		idle();
		busy_m <= 1'b0;
		wait_idle();
		chk({20'h0, col_m}, {20'h0, col});
		chk({13'h0, row_m}, {13'h0, row});
		chk({23'h0, pad_m}, 32'h0);
		rd(`NCI_REG_DATA, {16'h0, col[7:0], col[7:0] + 8'h1}, 1'b1);
		// extended status straight after an id read also needs the dummy
		wr(`NCI_REG_CMD, 32'h0);
		idle();
		wait_idle();
		wr(`NCI_REG_CMD, 32'h2);
		idle();
		wait_idle();
		chk({prev_m, cmd_m}, {24'h0, row[18] ? 8'hF3 : 8'hF2});
		sb = row[18] ? 8'hC2 : 8'hC1;
		rd(`NCI_REG_STAT, stat(sb, 0, 0, 1, 0), 1'b1);
		idle();
		idle();
		report_and_stop();
	end

endmodule : nci_host_bench

`default_nettype wire
